/* File: hmc_params.svh */
/*
  constants for the harvester mode controller: clock rate, time base,
  sampling and shutdown times, register offsets, field positions and
  the bit map of the synchronised pin vector.
  assumes the 20 MHz system clock; times derive cycle counts from it.
*/
`ifndef HMC_PARAMS_SVH
`define HMC_PARAMS_SVH

// clock rate and slow time base
`define CLK_FREQ_KHZ       20000
`define TICK_TIME_US       1000
`define TICK_CYCLES        (`TICK_TIME_US * `CLK_FREQ_KHZ / 1000)

// sampling, interval and critical shutdown times, then counts in ticks
`define SAMPLE_TIME_MS     328
`define PERIOD_TIME_S      21
`define CRIT_TIME_MS       600
`define SAMPLE_TICKS       (`SAMPLE_TIME_MS * 1000 / `TICK_TIME_US)
`define PERIOD_TICKS       (`PERIOD_TIME_S * 1000000 / `TICK_TIME_US)
`define CRIT_TICKS         (`CRIT_TIME_MS * 1000 / `TICK_TIME_US)

// settling time of the primary divider before the comparison is trusted
`define EVAL_TIME_US       10
`define EVAL_CYCLES        ((`EVAL_TIME_US * `CLK_FREQ_KHZ + 999) / 1000)

// counter widths
`define CNT_W              16
`define EVAL_W             8

// register port
`define ADDR_W             4
`define DATA_W             8
`define REG_CONTROL        4'h0
`define REG_STATUS         4'h4
`define CTRL_SAMPLE_BIT    0
`define CTRL_HOLD_BIT      1
`define CTRL_RESET         2'h0
`define STAT_MODE_LSB      0
`define STAT_READY_BIT     3
`define STAT_WARN_BIT      4
`define STAT_TRACK_BIT     5

// configuration codes
`define RATIO_IMPEDANCE    2'h3
`define CFG_RESERVED       3'h0

// bit map of the synchronised pin vector
`define SYNC_W             16
`define S_COLD             0
`define S_OVCH             1
`define S_OVCH_LOW         2
`define S_CHRDY            3
`define S_OVDIS            4
`define S_PRIMARY_CELL_INPUT             5
`define S_SRC_HI           6
`define S_SRC_LO           7
`define S_BAL_GND          8
`define S_LOW_EN           9
`define S_HIGH_EN          10
`define S_SEL_LSB          11
`define S_CFG_LSB          13

`endif

/* File: hmc_pkg.sv */
/*
  types shared by the mode controller and its sampling sequencer.
  assumes the constants header is included where widths are needed.
*/
package hmc_pkg;

  // operating modes of the power manager
  typedef enum logic [2:0] {
    MODE_DEEP_SLEEP = 3'b000,
    MODE_WAKE_UP    = 3'b001,
    MODE_NORMAL     = 3'b010,
    MODE_OVERVOLT   = 3'b011,
    MODE_PRIMARY    = 3'b100,
    MODE_SHUTDOWN   = 3'b101,
    MODE_EVAL_PRIMARY_CELL_INPUT  = 3'b110
  } mode_e;

endpackage

/* File: mppt_if.sv */
/*
  carrier between the mode controller and the sampling sequencer.
  assumes both ends run on the same clock and reset.
*/
`timescale 1ns/1ps
interface mppt_if;
  logic tick;            // one-cycle pulse of the slow time base
  logic run;             // tracking allowed in the current mode
  logic impedance_mode;  // constant-impedance matching selected
  logic src_high;        // source above target plus hysteresis
  logic src_low;         // source below target minus hysteresis
  logic sample_request;  // software asks for an immediate sample
  logic hold_off;        // software suspends periodic sampling
  logic sampling;        // source disconnected, voltage being sampled
  logic boost_request;   // hysteretic boost on request
  logic target_store;    // one-cycle pulse: store the new target

  modport ctrl (
    output tick, run, impedance_mode, src_high, src_low, sample_request, hold_off,
    input  sampling, boost_request, target_store
  );
  modport sampler (
    input  tick, run, impedance_mode, src_high, src_low, sample_request, hold_off,
    output sampling, boost_request, target_store
  );
endinterface

/* File: mppt_sampler.sv */
/*
  open-circuit sampling sequencer and hysteretic boost control.
  assumes tick is a one-cycle pulse on CLK and all inputs are synchronous.
*/
`timescale 1ns/1ps
`include "hmc_params.svh"
module mppt_sampler
  import hmc_pkg::*;
#(
  parameter int PERIOD_TICKS = `PERIOD_TICKS
)
(
  input  wire logic   CLK,
  input  wire logic   RSTN,
  mppt_if.sampler     bus
);

  logic [`CNT_W-1:0] period_cnt;   // ticks since the last sample
  logic [`CNT_W-1:0] sample_cnt;   // ticks within the current sample
  logic              period_done;  // interval elapsed
  logic              sample_done;  // sample window elapsed
  logic              start;        // begin a sample now

  assign period_done = bus.tick && (period_cnt == `CNT_W'(PERIOD_TICKS - 1));
  assign sample_done = bus.tick && (sample_cnt == `CNT_W'(`SAMPLE_TICKS - 1));
  // no open-circuit sampling when matching a constant impedance
  assign start = bus.run && !bus.sampling && !bus.impedance_mode &&
                 (bus.sample_request || (period_done && !bus.hold_off));

  // interval counter, restarted by every sample
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      period_cnt <= '0;
    else if (!bus.run || bus.sampling || start)
      period_cnt <= '0;
    else if (period_done)
      period_cnt <= period_cnt;
    else if (bus.tick)
      period_cnt <= period_cnt + `CNT_W'(1);
  end

  // sample window: source disconnected for the full window
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      bus.sampling     <= 1'b0;
      sample_cnt       <= '0;
      bus.target_store <= 1'b0;
    end
    else
    begin
      bus.target_store <= bus.sampling && sample_done && bus.run;
      if (!bus.run)
        bus.sampling <= 1'b0;
      else if (start)
        bus.sampling <= 1'b1;
      else if (sample_done)
        bus.sampling <= 1'b0;
      if (!bus.sampling)
        sample_cnt <= '0;
      else if (bus.tick)
        sample_cnt <= sample_cnt + `CNT_W'(1);
    end
  end

  // hysteretic boost control outside sampling
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      bus.boost_request <= 1'b0;
    else if (!bus.run || bus.sampling || start)
      bus.boost_request <= 1'b0;
    else if (bus.src_high)
      bus.boost_request <= 1'b1;
    else if (bus.src_low)
      bus.boost_request <= 1'b0;
  end

endmodule

/* File: harvester_mode_controller.sv */
/*
  mode controller of an energy-harvesting power manager: mode sequencing,
  power switch enables, regulator gating, status outputs, time base and
  a small register port.
  assumes threshold comparators and pins arrive asynchronously and are
  synchronised here; the analog switches act on the levels driven out.
*/
`timescale 1ns/1ps
`include "hmc_params.svh"
module harvester_mode_controller
  import hmc_pkg::*;
#(
  parameter int TICK_CYCLES  = `TICK_CYCLES,
  parameter int PERIOD_TICKS = `PERIOD_TICKS
)
(
  input  wire logic               CLK,
  input  wire logic               RSTN,
  input  wire logic               COLD_START_DONE,
  input  wire logic               BATT_ABOVE_OVCH,
  input  wire logic               BATT_ABOVE_OVCH_LOW,
  input  wire logic               BATT_ABOVE_CHRDY,
  input  wire logic               BATT_ABOVE_OVDIS,
  input  wire logic               PRIMARY_QUARTER_ABOVE,
  input  wire logic               SOURCE_ABOVE_TARGET,
  input  wire logic               SOURCE_BELOW_TARGET,
  input  wire logic               CELL_BALANCE_GROUNDED,
  input  wire logic               LOW_OUTPUT_ENABLE,
  input  wire logic               HIGH_OUTPUT_ENABLE,
  input  wire logic [1:0]         TRACKING_RATIO_SELECT,
  input  wire logic [2:0]         STORAGE_CONFIG,
  input  wire logic [`ADDR_W-1:0] ADDR,
  input  wire logic [`DATA_W-1:0] WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output logic      [`DATA_W-1:0] RDATA,
  output logic                    LOW_OUTPUT_ON,
  output logic                    HIGH_OUTPUT_ON,
  output logic                    STATUS_READY,
  output logic                    STATUS_WARNING,
  output logic                    STATUS_TRACKING,
  output logic                    SOURCE_ISOLATION_SWITCH,
  output logic                    BATTERY_SWITCH,
  output logic                    PRIMARY_SWITCH,
  output logic                    PRIMARY_DIVIDER_RETURN,
  output logic                    BOOST_ENABLE,
  output logic                    TARGET_STORE,
  output logic      [1:0]         TRACKING_RATIO,
  output logic                    IMPEDANCE_MATCH,
  output logic      [2:0]         THRESHOLD_SELECT,
  output logic                    BALANCE_ENABLE
);

  // synchroniser stages and the pin vector
  logic [`SYNC_W-1:0] pins_raw;      // asynchronous pin levels
  logic [`SYNC_W-1:0] sync_meta;     // first stage, read only by the second
  logic [`SYNC_W-1:0] pins;          // second stage, safe to use

  // time base
  logic [`CNT_W-1:0]  prescale;      // clock cycles within one tick
  logic               tick;          // one-cycle pulse every tick

  // mode machine
  mode_e              mode;          // current mode
  mode_e              next_mode;     // mode for the next cycle
  logic [`CNT_W-1:0]  crit_cnt;      // ticks spent in shutdown
  logic [`EVAL_W-1:0] eval_cnt;      // cycles of divider settling
  logic               ov_boost;      // hysteretic boost in overvoltage
  logic [2:0]         config_code;   // storage code caught at wake-up

  // software control
  logic [1:0]         control;       // hold bit and sample request pulse
  logic [`DATA_W-1:0] status_word;   // status register contents

  // named conditions
  logic               sel_control;   // address hits control
  logic               sel_status;    // address hits status
  logic               in_ready;      // regulators may be enabled
  logic               in_warn;       // warning modes
  logic               in_track;      // tracking modes
  logic               crit_done;     // critical time expired
  logic               eval_done;     // divider settled
  logic               config_ok;     // configuration code usable
  logic               next_iso;      // next source switch state
  logic               next_boost;    // next boost enable
  logic               next_batt;     // next battery switch state

  mppt_if             mp ();         // link to the sampling sequencer

  // gather every asynchronous input into one vector
  assign pins_raw = {STORAGE_CONFIG, TRACKING_RATIO_SELECT, HIGH_OUTPUT_ENABLE,
                     LOW_OUTPUT_ENABLE, CELL_BALANCE_GROUNDED, SOURCE_BELOW_TARGET,
                     SOURCE_ABOVE_TARGET, PRIMARY_QUARTER_ABOVE, BATT_ABOVE_OVDIS,
                     BATT_ABOVE_CHRDY, BATT_ABOVE_OVCH_LOW, BATT_ABOVE_OVCH,
                     COLD_START_DONE};

  // two flip-flops per pin before any logic looks at it
  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge CLK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          sync_meta[gi] <= 1'b0;
          pins[gi]      <= 1'b0;
        end
        else
        begin
          sync_meta[gi] <= pins_raw[gi];
          pins[gi]      <= sync_meta[gi];
        end
      end
    end
  endgenerate

  // slow time base from the system clock
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      prescale <= '0;
      tick     <= 1'b0;
    end
    else
    begin
      tick     <= (prescale == `CNT_W'(TICK_CYCLES - 1));
      prescale <= (prescale == `CNT_W'(TICK_CYCLES - 1)) ? '0 : prescale + `CNT_W'(1);
    end
  end

  // mode groups
  assign in_ready  = (mode == MODE_NORMAL) || (mode == MODE_OVERVOLT) ||
                     (mode == MODE_PRIMARY) || (mode == MODE_SHUTDOWN) ||
                     (mode == MODE_EVAL_PRIMARY_CELL_INPUT);
  assign in_warn   = (mode == MODE_PRIMARY) || (mode == MODE_SHUTDOWN);
  assign in_track  = (mode == MODE_WAKE_UP) || (mode == MODE_NORMAL) ||
                     (mode == MODE_SHUTDOWN) || (mode == MODE_EVAL_PRIMARY_CELL_INPUT);
  assign crit_done = tick && (crit_cnt == `CNT_W'(`CRIT_TICKS - 1));
  assign eval_done = (eval_cnt == `EVAL_W'(`EVAL_CYCLES - 1));
  assign config_ok = (pins[`S_CFG_LSB +: 3] != `CFG_RESERVED);

  // mode transitions
  always_comb
  begin
    next_mode = mode;
    case (mode)
      MODE_DEEP_SLEEP:
        // cold start only with a usable configuration
        if (pins[`S_COLD] && config_ok)
          next_mode = MODE_WAKE_UP;
      MODE_WAKE_UP:
        // regulators stay off until charge-ready
        if (pins[`S_CHRDY])
          next_mode = MODE_NORMAL;
      MODE_NORMAL:
        if (!pins[`S_OVDIS])
          next_mode = MODE_EVAL_PRIMARY_CELL_INPUT;
        else if (pins[`S_OVCH])
          next_mode = MODE_OVERVOLT;
      MODE_OVERVOLT:
        // battery drained by the load below discharge
        if (!pins[`S_OVDIS])
          next_mode = MODE_EVAL_PRIMARY_CELL_INPUT;
        else if (!pins[`S_OVCH_LOW] && !pins[`S_SRC_HI])
          next_mode = MODE_NORMAL;
      MODE_EVAL_PRIMARY_CELL_INPUT:
        // compare quarter primary voltage once the divider settled
        if (eval_done)
          next_mode = pins[`S_PRIMARY_CELL_INPUT] ? MODE_PRIMARY : MODE_SHUTDOWN;
      MODE_PRIMARY:
        if (pins[`S_CHRDY])
          next_mode = MODE_NORMAL;
      MODE_SHUTDOWN:
        if (pins[`S_CHRDY])
          next_mode = MODE_NORMAL;
        else if (crit_done)
          next_mode = MODE_DEEP_SLEEP;
      default:
        next_mode = MODE_DEEP_SLEEP;
    endcase
  end

  // mode register and per-mode timers
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mode     <= MODE_DEEP_SLEEP;
      crit_cnt <= '0;
      eval_cnt <= '0;
    end
    else
    begin
      mode <= next_mode;
      // shutdown time counted in slow ticks
      if (mode != MODE_SHUTDOWN)
        crit_cnt <= '0;
      else if (tick)
        crit_cnt <= crit_cnt + `CNT_W'(1);
      eval_cnt <= (mode == MODE_EVAL_PRIMARY_CELL_INPUT) ? eval_cnt + `EVAL_W'(1) : '0;
    end
  end

  // configuration caught when leaving deep sleep
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      config_code <= `CFG_RESERVED;
    else if (mode == MODE_DEEP_SLEEP)
      config_code <= pins[`S_CFG_LSB +: 3];
  end

  // overvoltage hysteresis: boost on below the low edge, off at overcharge
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      ov_boost <= 1'b0;
    else if (mode != MODE_OVERVOLT)
      ov_boost <= 1'b0;
    else if (pins[`S_OVCH])
      ov_boost <= 1'b0;
    else if (!pins[`S_OVCH_LOW])
      ov_boost <= 1'b1;
  end

  // sequencer inputs
  assign mp.tick           = tick;
  assign mp.run            = in_track;
  assign mp.impedance_mode = (pins[`S_SEL_LSB +: 2] == `RATIO_IMPEDANCE);
  assign mp.src_high       = pins[`S_SRC_HI];
  assign mp.src_low        = pins[`S_SRC_LO];
  assign mp.sample_request = control[`CTRL_SAMPLE_BIT];
  assign mp.hold_off       = control[`CTRL_HOLD_BIT];

  mppt_sampler #(
    .PERIOD_TICKS (PERIOD_TICKS)
  ) u_sampler (
    .CLK  (CLK),
    .RSTN (RSTN),
    .bus  (mp.sampler)
  );

  // switch and boost decisions per mode
  assign next_iso   = (mode == MODE_OVERVOLT)  ? ov_boost :
                      (mode == MODE_PRIMARY)   ? 1'b0 :
                      !mp.sampling;
  assign next_boost = (mode == MODE_OVERVOLT)  ? ov_boost :
                      (mode == MODE_PRIMARY)   ? !mp.sampling :
                      (mode == MODE_DEEP_SLEEP) ? 1'b0 :
                      mp.boost_request;
  assign next_batt  = (mode == MODE_WAKE_UP) || (mode == MODE_NORMAL) ||
                      (mode == MODE_OVERVOLT) || (mode == MODE_PRIMARY);

  // power outputs, all registered
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      LOW_OUTPUT_ON           <= 1'b0;
      HIGH_OUTPUT_ON          <= 1'b0;
      SOURCE_ISOLATION_SWITCH <= 1'b0;
      BATTERY_SWITCH          <= 1'b0;
      PRIMARY_SWITCH          <= 1'b0;
      PRIMARY_DIVIDER_RETURN  <= 1'b0;
      BOOST_ENABLE            <= 1'b0;
    end
    else
    begin
      LOW_OUTPUT_ON           <= in_ready && pins[`S_LOW_EN];
      HIGH_OUTPUT_ON          <= in_ready && pins[`S_HIGH_EN];
      SOURCE_ISOLATION_SWITCH <= next_iso;
      BATTERY_SWITCH          <= next_batt;
      PRIMARY_SWITCH          <= (mode == MODE_PRIMARY);
      PRIMARY_DIVIDER_RETURN  <= (mode == MODE_EVAL_PRIMARY_CELL_INPUT);
      BOOST_ENABLE            <= next_boost;
    end
  end

  // status and configuration outputs, all registered
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      STATUS_READY     <= 1'b0;
      STATUS_WARNING   <= 1'b0;
      STATUS_TRACKING  <= 1'b0;
      TARGET_STORE     <= 1'b0;
      TRACKING_RATIO   <= 2'h0;
      IMPEDANCE_MATCH  <= 1'b0;
      THRESHOLD_SELECT <= `CFG_RESERVED;
      BALANCE_ENABLE   <= 1'b0;
    end
    else
    begin
      STATUS_READY     <= in_ready;
      STATUS_WARNING   <= in_warn;
      STATUS_TRACKING  <= mp.sampling;
      TARGET_STORE     <= mp.target_store;
      TRACKING_RATIO   <= pins[`S_SEL_LSB +: 2];
      IMPEDANCE_MATCH  <= mp.impedance_mode;
      THRESHOLD_SELECT <= config_code;
      BALANCE_ENABLE   <= !pins[`S_BAL_GND];
    end
  end

  // register decode
  assign sel_control = (ADDR == `REG_CONTROL);
  assign sel_status  = (ADDR == `REG_STATUS);
  assign status_word = {2'h0, mp.sampling, in_warn, in_ready, mode};

  // control register: hold bit stored, sample request lasts one cycle
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      control <= `CTRL_RESET;
    else if (WR && sel_control)
      control <= WDATA[1:0];
    else
      control <= {control[`CTRL_HOLD_BIT], 1'b0};
  end

  // read data in the cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      RDATA <= '0;
    else if (RD && sel_control)
      RDATA <= {6'h0, control[`CTRL_HOLD_BIT], 1'b0};
    else if (RD && sel_status)
      RDATA <= status_word;
    else
      RDATA <= '0;
  end

endmodule

/* File: hmc_checker.sv */
/*
  port checker for the harvester mode controller, bound to its top module.
  assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "hmc_params.svh"
module hmc_checker
  import hmc_pkg::*;
#(
  parameter int TICK_CYCLES = 4
)
(
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       LOW_OUTPUT_ENABLE,
  input wire logic       LOW_OUTPUT_ON,
  input wire logic       HIGH_OUTPUT_ON,
  input wire logic       STATUS_READY,
  input wire logic       STATUS_WARNING,
  input wire logic       STATUS_TRACKING,
  input wire logic       SOURCE_ISOLATION_SWITCH,
  input wire logic       PRIMARY_SWITCH,
  input wire logic       BOOST_ENABLE,
  input wire logic       TARGET_STORE,
  input wire logic [1:0] TRACKING_RATIO_SELECT,
  input wire logic [1:0] TRACKING_RATIO,
  input wire logic       IMPEDANCE_MATCH,
  input wire logic       CELL_BALANCE_GROUNDED,
  input wire logic       BALANCE_ENABLE
);
  localparam int MAX_TRK = `SAMPLE_TICKS * TICK_CYCLES + TICK_CYCLES;  // longest window
  logic [31:0] trk_cnt;  // cycles of the current sample window
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // counts how long the tracking status has stood
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN) trk_cnt <= '0;
    else trk_cnt <= STATUS_TRACKING ? trk_cnt + 32'h1 : '0;
  sequence sel_steady;
    $stable(TRACKING_RATIO_SELECT)[*4];
  endsequence
  low_gate_a: assert property (!LOW_OUTPUT_ENABLE[*3] |=> !LOW_OUTPUT_ON)
    else $error("low output on without its enable");
  not_ready_a: assert property (!STATUS_READY |-> !LOW_OUTPUT_ON && !HIGH_OUTPUT_ON)
    else $error("regulator on while not ready");
  warn_ready_a: assert property (STATUS_WARNING |-> STATUS_READY)
    else $error("warning without ready");
  primary_path_a: assert property (PRIMARY_SWITCH |->
    !SOURCE_ISOLATION_SWITCH && STATUS_WARNING)
    else $error("primary switch with source connected");
  sample_open_a: assert property (STATUS_TRACKING |->
    !SOURCE_ISOLATION_SWITCH && !BOOST_ENABLE)
    else $error("source connected during sampling");
  window_len_a: assert property (trk_cnt <= MAX_TRK)
    else $error("sample window too long");
  store_pulse_a: assert property (TARGET_STORE |=> !TARGET_STORE)
    else $error("target store longer than one cycle");
  ratio_copy_a: assert property (sel_steady |=>
    TRACKING_RATIO == $past(TRACKING_RATIO_SELECT) &&
    IMPEDANCE_MATCH == (TRACKING_RATIO == `RATIO_IMPEDANCE))
    else $error("tracking ratio differs from select");
  balance_off_a: assert property (CELL_BALANCE_GROUNDED[*4] |=> !BALANCE_ENABLE)
    else $error("balancing on with grounded pin");
  rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data outside read answer");
endmodule
bind harvester_mode_controller hmc_checker #(.TICK_CYCLES(TICK_CYCLES)) hmc_checker_i (.*);

/* File: host_model.sv */
/*
  host that drives the two regulator enables after a clock edge.
  assumes it may request outputs before ready, as a careless host would.
*/
`timescale 1ns/1ps
module host_model
(
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic [1:0] want,
  output logic            LOW_OUTPUT_ENABLE,
  output logic            HIGH_OUTPUT_ENABLE
);
  // each enable is driven on its own, all four combinations possible
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN) {HIGH_OUTPUT_ENABLE, LOW_OUTPUT_ENABLE} <= 2'h0;
    else {HIGH_OUTPUT_ENABLE, LOW_OUTPUT_ENABLE} <= want;
endmodule

/* File: harvester_mode_controller_tb.sv */
/*
  self-checking bench for the harvester mode controller and a host model.
  assumes a 4-cycle tick and the status layout of the register port.
*/
`timescale 1ns/1ps
`include "hmc_params.svh"
module harvester_mode_controller_tb;
  import hmc_pkg::*;
  localparam int TC = 4;  // clocks per tick
  logic CLK = 0, RSTN = 0, COLD_START_DONE = 0, BATT_ABOVE_OVCH = 0, BATT_ABOVE_OVCH_LOW = 0;
  logic BATT_ABOVE_CHRDY = 0, BATT_ABOVE_OVDIS = 0, PRIMARY_QUARTER_ABOVE = 0;
  logic SOURCE_ABOVE_TARGET = 0, SOURCE_BELOW_TARGET = 0, CELL_BALANCE_GROUNDED = 0;
  logic LOW_OUTPUT_ENABLE, HIGH_OUTPUT_ENABLE, WR = 0, RD = 0;
  logic [1:0] TRACKING_RATIO_SELECT = 2'h0, want = 2'h0, TRACKING_RATIO;
  logic [2:0] STORAGE_CONFIG = 3'h0, THRESHOLD_SELECT;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00, RDATA;
  logic LOW_OUTPUT_ON, HIGH_OUTPUT_ON, STATUS_READY, STATUS_WARNING, STATUS_TRACKING;
  logic SOURCE_ISOLATION_SWITCH, BATTERY_SWITCH, PRIMARY_SWITCH, PRIMARY_DIVIDER_RETURN;
  logic BOOST_ENABLE, TARGET_STORE, IMPEDANCE_MATCH, BALANCE_ENABLE;
  int errors = 0, cmp_count = 0;
  harvester_mode_controller #(.TICK_CYCLES(TC), .PERIOD_TICKS(20))
    harvester_mode_controller_i (.*);
  host_model host_model_i (.CLK(CLK), .RSTN(RSTN), .want(want),
    .LOW_OUTPUT_ENABLE(LOW_OUTPUT_ENABLE), .HIGH_OUTPUT_ENABLE(HIGH_OUTPUT_ENABLE));
  // 50 ns clock
  always #25 CLK = ~CLK;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 check(RDATA, exp);
  endtask
  task automatic t_reserved;
    COLD_START_DONE <= 1'b1;
    cy(10);
    rdchk(4'h4, 8'h00);
    rdchk(4'h8, 8'h00);
    wr(4'h0, 8'h02);
    rdchk(4'h0, 8'h02);
  endtask
  task automatic t_wake;
    STORAGE_CONFIG <= 3'h7; want <= 2'h3;
    cy(10);
    rdchk(4'h4, 8'h01);
    check({STATUS_READY, LOW_OUTPUT_ON, HIGH_OUTPUT_ON}, 3'h0);
    check(THRESHOLD_SELECT, 3'h7);
  endtask
  task automatic t_normal;
    BATT_ABOVE_OVDIS <= 1'b1; BATT_ABOVE_CHRDY <= 1'b1;
    cy(10);
    rdchk(4'h4, 8'h0A);
    check(BATTERY_SWITCH, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      want <= i[1:0];
      cy(8);
      check({HIGH_OUTPUT_ON, LOW_OUTPUT_ON}, i[1:0]);
    end
  endtask
  task automatic t_ratio;
    for (int i = 0; i < 4; i++)
    begin
      TRACKING_RATIO_SELECT <= i[1:0]; CELL_BALANCE_GROUNDED <= i[0];
      cy(6);
      check({IMPEDANCE_MATCH, TRACKING_RATIO}, {i == 3, i[1:0]});
      check(BALANCE_ENABLE, !i[0]);
    end
    TRACKING_RATIO_SELECT <= 2'h0;
  endtask
  task automatic t_boost;
    SOURCE_ABOVE_TARGET <= 1'b1;
    cy(8);
    check(BOOST_ENABLE, 1'b1);
    SOURCE_ABOVE_TARGET <= 1'b0; SOURCE_BELOW_TARGET <= 1'b1;
    cy(8);
    check(BOOST_ENABLE, 1'b0);
    SOURCE_BELOW_TARGET <= 1'b0;
  endtask
  task automatic t_sample;
    int n;
    int st;
    n = 0;
    st = 0;
    wr(4'h0, 8'h03);
    cy(6);
    check(STATUS_TRACKING, 1'b1);
    while (STATUS_TRACKING === 1'b1 && n < 3000)
    begin
      cy(1);
      n++;
      if (TARGET_STORE === 1'b1) st++;
    end
    cy(4);
    if (TARGET_STORE === 1'b1) st++;
    check(n > 328 * TC - TC - 8 && n <= 328 * TC + TC, 1'b1);
    check(st == 1, 1'b1);
    TRACKING_RATIO_SELECT <= `RATIO_IMPEDANCE;
    wr(4'h0, 8'h03);
    cy(20);
    check(STATUS_TRACKING, 1'b0);
    TRACKING_RATIO_SELECT <= 2'h0;
    // clearing the hold lets the interval counter start a sample by itself
    wr(4'h0, 8'h00);
    cy(20 * TC + 8);
    check(STATUS_TRACKING, 1'b1);
    wr(4'h0, 8'h02);
  endtask
  task automatic t_overvolt;
    BATT_ABOVE_OVCH <= 1'b1; BATT_ABOVE_OVCH_LOW <= 1'b1;
    cy(10);
    rdchk(4'h4, 8'h0B);
    check({SOURCE_ISOLATION_SWITCH, BOOST_ENABLE}, 2'h0);
    BATT_ABOVE_OVCH <= 1'b0; BATT_ABOVE_OVCH_LOW <= 1'b0;
    cy(10);
    rdchk(4'h4, 8'h0A);
  endtask
  task automatic t_primary;
    PRIMARY_QUARTER_ABOVE <= 1'b1; BATT_ABOVE_OVDIS <= 1'b0; BATT_ABOVE_CHRDY <= 1'b0;
    cy(100);
    check(PRIMARY_DIVIDER_RETURN, 1'b1);
    cy(130);
    rdchk(4'h4, 8'h1C);
    check({PRIMARY_SWITCH, SOURCE_ISOLATION_SWITCH, STATUS_WARNING}, 3'h5);
    BATT_ABOVE_OVDIS <= 1'b1; BATT_ABOVE_CHRDY <= 1'b1;
    cy(10);
    rdchk(4'h4, 8'h0A);
  endtask
  task automatic t_shutdown(input logic recover);
    // no primary cell: its sense input is held low as a grounded pin would be
    PRIMARY_QUARTER_ABOVE <= 1'b0; BATT_ABOVE_OVDIS <= 1'b0; BATT_ABOVE_CHRDY <= 1'b0;
    cy(230);
    rdchk(4'h4, 8'h1D);
    check({HIGH_OUTPUT_ON, LOW_OUTPUT_ON}, 2'h3);
    if (recover)
    begin
      BATT_ABOVE_OVDIS <= 1'b1; BATT_ABOVE_CHRDY <= 1'b1;
      cy(10);
      rdchk(4'h4, 8'h0A);
    end
    else
    begin
      COLD_START_DONE <= 1'b0;
      cy(560 * TC);
      check(STATUS_WARNING, 1'b1);
      cy(60 * TC);
      rdchk(4'h4, 8'h00);
      check({BATTERY_SWITCH, HIGH_OUTPUT_ON, LOW_OUTPUT_ON}, 3'h0);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    #1 check(STATUS_READY, 1'b0);
    t_reserved;
    t_wake;
    t_normal;
    t_ratio;
    t_boost;
    t_sample;
    t_overvolt;
    t_primary;
    t_shutdown(1'b1);
    t_shutdown(1'b0);
    give_verdict;
  end
  // watchdog sized well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge CLK);
    errors++;
    give_verdict;
  end
endmodule
